// File: rtl/pcp_socket_power_control.sv
// socket power control register bank with power switch request outputs
//
// How it works
// - output enable bit 7 gates all 16-bit card outputs; zero disables them.
// - older layout reads bit 6 as zero.
// - older layout bit 5 enables automatic supply switching from card detect.
// - older layout bit 4 enables supply; level comes from external select.
// - older layout reads bits 3 and 2 as zero.
// - older layout program field: 00 off, 10 twelve volts, 01 supply.
// - program request ignored while supply is off; newer needs 5 or 3.3 volts.
// - newer layout bits 6 and 5 read zero and ignore writes.
// - newer layout supply field: 00 off, 10 five, 01 off, 11 3.3.
// - newer layout bit 2 reads zero and ignores writes.
// - newer layout program field: 00 off, 10 twelve, 01 supply, 11 off.
// - marked bits cleared by bus reset only while wake events disabled.
// - power register sits at offset 802h and resets to zero.
// - general control register at 803h is read/write, resets to zero.
// - revision field resets to 0100; writing 0010 selects the older layout.
// - card power status reads one while supply is on.
`timescale 1ns/1ps
module pcp_socket_power_control (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic global_reset_n_in,
  input wire logic bus_reset_n_in,
  input wire logic wake_event_enable_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic supply_level_select_in,
  input wire logic card_detect1_n_in,
  input wire logic card_detect2_n_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  output logic card_output_enable_out,
  output logic [1:0] supply_voltage_request_out,
  output logic [1:0] program_voltage_request_out,
  output logic card_power_status_out,
  output logic [7:0] general_control_out
);
  import pcp_pkg::*;

  // ==========================================================
  // state
  logic [7:0] power_reg;
  logic [7:0] general_reg;
  logic [3:0] compat_revision_field;
  logic layout_old;
  logic card_present;
  logic hard_clear;
  logic bus_clear;
  logic [7:0] write_mask;
  logic [7:0] keep_mask;
  logic [7:0] next_power;
  logic [7:0] next_general;
  logic [7:0] power_view;
  logic [7:0] status_view;
  logic [7:0] ident_view;
  logic [7:0] next_rdata;

  pcp_power_if pwr ();

  // ==========================================================
  // reset sources
  // global reset and the system reset clear everything but the read port, which only the system reset clears
  assign hard_clear = reset_in || !global_reset_n_in;
  assign bus_clear = !bus_reset_n_in;

  // ==========================================================
  // layout selection
  assign layout_old = (compat_revision_field == PCP_REV_OLD);
  assign write_mask = layout_old ? PCP_OLD_WRITE_MASK : PCP_NEW_WRITE_MASK;
  // with wake events enabled the marked bits ride through bus reset
  assign keep_mask = wake_event_enable_in ?
                     (layout_old ? PCP_OLD_KEEP_MASK : PCP_NEW_KEEP_MASK) : 8'h00;
  assign card_present = !card_detect1_n_in && !card_detect2_n_in;

  // ==========================================================
  // power control register
  always_comb begin
    next_power = power_reg;
    if (reg_write_in && reg_addr_in == PCP_OFS_POWER) begin
      // a write stores zero in the current layout's reserved positions
      next_power = reg_wdata_in & write_mask;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (hard_clear) begin
      power_reg <= PCP_POWER_RESET;
    end else if (bus_clear) begin
      power_reg <= power_reg & keep_mask;
    end else begin
      power_reg <= next_power;
    end
  end

  // ==========================================================
  // interrupt and general control register
  always_comb begin
    next_general = general_reg;
    if (reg_write_in && reg_addr_in == PCP_OFS_GENERAL) begin
      next_general = reg_wdata_in & PCP_GENERAL_WRITE_MASK;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (hard_clear) begin
      general_reg <= PCP_GENERAL_RESET;
    end else if (bus_clear) begin
      general_reg <= general_reg &
                     (wake_event_enable_in ? PCP_GENERAL_KEEP_MASK : 8'h00);
    end else begin
      general_reg <= next_general;
    end
  end

  // ==========================================================
  // compatibility revision field, cleared only by global or system reset
  always_ff @(posedge sys_clk_in) begin
    if (hard_clear) begin
      compat_revision_field <= PCP_REV_RESET;
    end else if (reg_write_in && reg_addr_in == PCP_OFS_IDENT) begin
      compat_revision_field <= reg_wdata_in[PCP_REV_LSB +: 4];
    end
  end

  // ==========================================================
  // decoder hookup
  assign pwr.layout_old = layout_old;
  assign pwr.power_reg = power_reg;
  assign pwr.supply_level_select = supply_level_select_in;
  assign pwr.card_present = card_present;

  pcp_power_decode i_pcp_power_decode (
    .pwr(pwr.decoder)
  );

  // ==========================================================
  // switch request, output enable, power status and general control outputs, registered one edge after the store
  always_ff @(posedge sys_clk_in) begin
    if (hard_clear) begin
      supply_voltage_request_out <= PCP_SUPPLY_0V;
    end else begin
      supply_voltage_request_out <= pwr.supply_request;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (hard_clear) begin
      program_voltage_request_out <= PCP_PROGRAM_OFF;
    end else begin
      program_voltage_request_out <= pwr.program_request;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (hard_clear) begin
      card_output_enable_out <= 1'b0;
    end else begin
      card_output_enable_out <= power_reg[PCP_BIT_OUTPUT_ENABLE];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (hard_clear) begin
      card_power_status_out <= 1'b0;
    end else begin
      card_power_status_out <= pwr.supply_on;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (hard_clear) begin
      general_control_out <= PCP_GENERAL_RESET;
    end else begin
      general_control_out <= general_reg;
    end
  end

  // ==========================================================
  // read views
  // layout mask hides bits left over from the other layout
  assign power_view = power_reg & write_mask;
  always_comb begin
    status_view = 8'h00;
    status_view[PCP_BIT_CARD_POWER] = pwr.supply_on;
    status_view[PCP_BIT_DETECT2] = !card_detect2_n_in;
    status_view[PCP_BIT_DETECT1] = !card_detect1_n_in;
    ident_view = 8'h00;
    ident_view[PCP_REV_LSB +: 4] = compat_revision_field;
  end

  always_comb begin
    unique case (reg_addr_in)
      PCP_OFS_IDENT: next_rdata = ident_view;
      PCP_OFS_STATUS: next_rdata = status_view;
      PCP_OFS_POWER: next_rdata = power_view;
      PCP_OFS_GENERAL: next_rdata = general_reg;
      default: next_rdata = PCP_READ_IDLE;
    endcase
  end

  // ==========================================================
  // read port: data one edge after the strobe, zero otherwise
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      reg_rdata_out <= PCP_READ_IDLE;
    end else begin
      reg_rdata_out <= reg_read_in ? next_rdata : PCP_READ_IDLE;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_read_in;
    end
  end

endmodule

// File: rtl/pcp_pkg.sv
// constants for the socket power control register bank
package pcp_pkg;

  // ==========================================================
  // register offsets, socket-relative
  localparam logic [11:0] PCP_OFS_IDENT = 12'h800;
  localparam logic [11:0] PCP_OFS_STATUS = 12'h801;
  localparam logic [11:0] PCP_OFS_POWER = 12'h802;
  localparam logic [11:0] PCP_OFS_GENERAL = 12'h803;

  // ==========================================================
  // reset values
  localparam logic [7:0] PCP_POWER_RESET = 8'h00;
  localparam logic [7:0] PCP_GENERAL_RESET = 8'h00;
  localparam logic [3:0] PCP_REV_RESET = 4'h4;
  localparam logic [3:0] PCP_REV_OLD = 4'h2;
  localparam logic [7:0] PCP_READ_IDLE = 8'h00;

  // ==========================================================
  // power, status and ident register field positions
  localparam int PCP_BIT_OUTPUT_ENABLE = 7;
  localparam int PCP_BIT_AUTO_SWITCH = 5;
  localparam int PCP_BIT_SUPPLY_ENABLE = 4;
  localparam int PCP_SUPPLY_LSB = 3;
  localparam int PCP_PROGRAM_LSB = 0;
  localparam int PCP_BIT_CARD_POWER = 6;
  localparam int PCP_BIT_DETECT2 = 3;
  localparam int PCP_BIT_DETECT1 = 2;
  localparam int PCP_REV_LSB = 0;

  // writable bits per layout; all others are reserved and read as zero
  localparam logic [7:0] PCP_OLD_WRITE_MASK = 8'hB3;
  localparam logic [7:0] PCP_NEW_WRITE_MASK = 8'h9B;
  // bits that survive a bus reset while wake events are enabled
  localparam logic [7:0] PCP_OLD_KEEP_MASK = 8'h20;
  localparam logic [7:0] PCP_NEW_KEEP_MASK = 8'h9B;
  localparam logic [7:0] PCP_GENERAL_KEEP_MASK = 8'h60;
  localparam logic [7:0] PCP_GENERAL_WRITE_MASK = 8'hFF;

  // ==========================================================
  // supply and programming voltage encodings
  localparam logic [1:0] PCP_SUPPLY_0V = 2'h0;
  localparam logic [1:0] PCP_SUPPLY_5V = 2'h2;
  localparam logic [1:0] PCP_SUPPLY_RESERVED_BITS = 2'h1;
  localparam logic [1:0] PCP_SUPPLY_3V3 = 2'h3;
  localparam logic [1:0] PCP_PROGRAM_OFF = 2'h0;
  localparam logic [1:0] PCP_PROGRAM_12V = 2'h2;
  localparam logic [1:0] PCP_PROGRAM_VCC = 2'h1;
  localparam logic [1:0] PCP_PROGRAM_RESERVED_BITS = 2'h3;

endpackage

// File: rtl/pcp_power_if.sv
// carrier between the register bank and the power request decoder
`timescale 1ns/1ps
interface pcp_power_if;
  logic layout_old;
  logic [7:0] power_reg;
  logic supply_level_select;
  logic card_present;
  logic [1:0] supply_request;
  logic [1:0] program_request;
  logic supply_on;

  modport bank (
    output layout_old,
    output power_reg,
    output supply_level_select,
    output card_present,
    input supply_request,
    input program_request,
    input supply_on
  );

  modport decoder (
    input layout_old,
    input power_reg,
    input supply_level_select,
    input card_present,
    output supply_request,
    output program_request,
    output supply_on
  );
endinterface

// File: rtl/pcp_power_decode.sv
// decodes the stored power register into switch requests
`timescale 1ns/1ps
module pcp_power_decode (
  pcp_power_if.decoder pwr
);
  import pcp_pkg::*;

  logic [1:0] supply_field;
  logic [1:0] program_field;
  logic old_supply_on;
  logic [1:0] old_supply_level;

  assign supply_field = pwr.power_reg[PCP_SUPPLY_LSB +: 2];
  assign program_field = pwr.power_reg[PCP_PROGRAM_LSB +: 2];

  // ==========================================================
  // older layout: enable bit plus external level select
  always_comb begin
    // auto switching cuts supply while no card is seated
    old_supply_on = pwr.power_reg[PCP_BIT_SUPPLY_ENABLE] &&
                    (!pwr.power_reg[PCP_BIT_AUTO_SWITCH] || pwr.card_present);
    old_supply_level = pwr.supply_level_select ? PCP_SUPPLY_3V3 : PCP_SUPPLY_5V;
  end

  // ==========================================================
  // supply request and on/off state
  always_comb begin
    if (pwr.layout_old) begin
      pwr.supply_request = old_supply_on ? old_supply_level : PCP_SUPPLY_0V;
    end else begin
      unique case (supply_field)
        PCP_SUPPLY_5V: pwr.supply_request = PCP_SUPPLY_5V;
        PCP_SUPPLY_3V3: pwr.supply_request = PCP_SUPPLY_3V3;
        default: pwr.supply_request = PCP_SUPPLY_0V;
      endcase
    end
    pwr.supply_on = (pwr.supply_request != PCP_SUPPLY_0V);
  end

  // ==========================================================
  // programming voltage, ignored with supply off
  always_comb begin
    if (!pwr.supply_on) begin
      pwr.program_request = PCP_PROGRAM_OFF;
    end else begin
      unique case (program_field)
        PCP_PROGRAM_12V: pwr.program_request = PCP_PROGRAM_12V;
        PCP_PROGRAM_VCC: pwr.program_request = PCP_PROGRAM_VCC;
        // reserved code drives nothing rather than guess a level
        default: pwr.program_request = PCP_PROGRAM_OFF;
      endcase
    end
  end

endmodule

// File: verification/pcp_socket_power_control_properties.sv
// checker for the socket power control register bank ports
`timescale 1ns/1ps
module pcp_socket_power_control_properties (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic global_reset_n_in,
  input wire logic bus_reset_n_in,
  input wire logic [11:0] reg_addr_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic reg_rvalid_out,
  input wire logic card_output_enable_out,
  input wire logic [1:0] supply_voltage_request_out,
  input wire logic [1:0] program_voltage_request_out,
  input wire logic card_power_status_out,
  input wire logic [7:0] general_control_out
);
  import pcp_pkg::*;
  // ==========================================================
  // sequences
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_clean; global_reset_n_in && bus_reset_n_in; endsequence
  sequence s_pwr_wr; reg_write_in && reg_addr_in == PCP_OFS_POWER ##0 s_clean; endsequence
  sequence s_gen_wr; reg_write_in && reg_addr_in == PCP_OFS_GENERAL ##0 s_clean; endsequence
  // ==========================================================
  // read port, power requests, output enable, general control copy and global clear
  AST_READ_ANSWER: assert property (reg_read_in |=> reg_rvalid_out)
    else $error("read strobe got no answer");
  AST_READ_IDLE: assert property (!reg_rvalid_out |-> reg_rdata_out == PCP_READ_IDLE)
    else $error("read data not idle");
  AST_VALID_CAUSE: assert property (reg_rvalid_out |-> $past(reg_read_in))
    else $error("read valid without strobe");
  AST_PROG_GATED: assert property (supply_voltage_request_out == PCP_SUPPLY_0V |->
    program_voltage_request_out == PCP_PROGRAM_OFF) else $error("program on without supply");
  AST_STATUS: assert property (card_power_status_out ==
    (supply_voltage_request_out != PCP_SUPPLY_0V)) else $error("power status wrong");
  AST_SUPPLY_CODE: assert property (supply_voltage_request_out != PCP_SUPPLY_RESERVED_BITS)
    else $error("reserved supply code driven");
  AST_PROG_CODE: assert property (program_voltage_request_out != PCP_PROGRAM_RESERVED_BITS)
    else $error("reserved program code driven");
  AST_OE_FOLLOWS: assert property (s_pwr_wr ##1 s_clean |-> ##1
    card_output_enable_out == $past(reg_wdata_in[PCP_BIT_OUTPUT_ENABLE], 2))
    else $error("output enable not following write");
  AST_GEN_FOLLOWS: assert property (s_gen_wr ##1 s_clean |-> ##1
    general_control_out == $past(reg_wdata_in, 2)) else $error("general copy wrong");
  AST_GLOBAL_CLEAR: assert property (!global_reset_n_in |=> !card_output_enable_out &&
    supply_voltage_request_out == PCP_SUPPLY_0V && general_control_out == 8'h00)
    else $error("outputs not cleared by global reset");
endmodule
bind pcp_socket_power_control pcp_socket_power_control_properties i_props (
  .sys_clk_in(sys_clk_in), .reset_in(reset_in), .global_reset_n_in(global_reset_n_in),
  .bus_reset_n_in(bus_reset_n_in), .reg_addr_in(reg_addr_in), .reg_write_in(reg_write_in),
  .reg_read_in(reg_read_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .card_output_enable_out(card_output_enable_out),
  .supply_voltage_request_out(supply_voltage_request_out),
  .program_voltage_request_out(program_voltage_request_out),
  .card_power_status_out(card_power_status_out), .general_control_out(general_control_out));

// File: verification/pcp_socket_model.sv
// socket model: card detect pins and the supply level strap
`timescale 1ns/1ps
module pcp_socket_model (
  input wire logic clk_in,
  input wire logic inserted_in,
  input wire logic level_in,
  output logic level_select_out,
  output logic card_detect1_n_out,
  output logic card_detect2_n_out
);
  // ==========================================================
  // card seating
  // second detect lags one clock: cards rarely seat both pins at once
  initial begin
    card_detect1_n_out = 1'b1;
    card_detect2_n_out = 1'b1;
  end
  always @(posedge clk_in) begin
    card_detect1_n_out <= !inserted_in;
    card_detect2_n_out <= card_detect1_n_out;
  end
  assign level_select_out = level_in;
endmodule

// File: verification/pcp_socket_power_control_bench.sv
// self-checking bench for the socket power control register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module pcp_socket_power_control_bench;
  import pcp_pkg::*;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic global_reset_n = 1'b1;
  logic bus_reset_n = 1'b1;
  logic wake = 1'b0;
  logic [11:0] addr = 12'h000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic inserted = 1'b0;
  logic level = 1'b0;
  logic sel, cd1_n, cd2_n, rvalid, oe, status;
  logic [7:0] rdata, gen;
  logic [1:0] sup, prog;
  logic [31:0] seed = 32'hC9C7AE91;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  pcp_socket_power_control i_pcp_socket_power_control (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .global_reset_n_in(global_reset_n),
    .bus_reset_n_in(bus_reset_n), .wake_event_enable_in(wake), .reg_addr_in(addr),
    .reg_write_in(wr_en), .reg_read_in(rd_en), .reg_wdata_in(wdata),
    .supply_level_select_in(sel), .card_detect1_n_in(cd1_n), .card_detect2_n_in(cd2_n),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .card_output_enable_out(oe),
    .supply_voltage_request_out(sup), .program_voltage_request_out(prog),
    .card_power_status_out(status), .general_control_out(gen));
  pcp_socket_model i_pcp_socket_model (.clk_in(sys_clk_in), .inserted_in(inserted),
    .level_in(level), .level_select_out(sel), .card_detect1_n_out(cd1_n),
    .card_detect2_n_out(cd2_n));
  // ==========================================================
  // helpers
  initial begin
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  function automatic logic [1:0] exp_sup(logic [7:0] d, logic old);
    if (old) return (d[4] && (!d[5] || inserted)) ? (level ? PCP_SUPPLY_3V3 : PCP_SUPPLY_5V)
      : PCP_SUPPLY_0V;
    return (d[4:3] == PCP_SUPPLY_RESERVED_BITS) ? PCP_SUPPLY_0V : d[4:3];
  endfunction
  function automatic logic [1:0] exp_prog(logic [7:0] d, logic [1:0] s);
    return (s == PCP_SUPPLY_0V || d[1:0] == PCP_PROGRAM_RESERVED_BITS) ? PCP_PROGRAM_OFF : d[1:0];
  endfunction
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk_in);
    wr_en <= 1'b0;
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk_in);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk_in);
    rd_en <= 1'b0;
    @(negedge sys_clk_in);
    `CHK("read valid", 1'b1, rvalid)
    `CHK("read data", e, rdata)
  endtask
  // called right after a read, so the requests are two edges past the write
  task automatic out_chk(input logic [7:0] d, input logic old);
    `CHK("output enable", d[7], oe)
    `CHK("supply request", exp_sup(d, old), sup)
    `CHK("program request", exp_prog(d, exp_sup(d, old)), prog)
    `CHK("power status", exp_sup(d, old) != PCP_SUPPLY_0V, status)
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================
  // watchdog, whole run needs under 3000 cycles
  always @(posedge sys_clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      summarize();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    logic [7:0] d;
    logic [1:0] s;
    repeat (6) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    rd_chk(PCP_OFS_IDENT, {4'h0, PCP_REV_RESET});
    rd_chk(PCP_OFS_POWER, PCP_POWER_RESET);
    rd_chk(PCP_OFS_GENERAL, PCP_GENERAL_RESET);
    done("reset values");
    for (int i = 0; i < 24; i++) begin
      d = rnd();
      if (i < 16) d = {d[7:5], i[3:2], d[2], i[1:0]};
      wr(PCP_OFS_POWER, d);
      rd_chk(PCP_OFS_POWER, d & PCP_NEW_WRITE_MASK);
      out_chk(d, 1'b0);
    end
    wr(12'h804, 8'hFF);
    rd_chk(12'h804, PCP_READ_IDLE);
    for (int i = 0; i < 4; i++) begin
      d = rnd();
      wr(PCP_OFS_GENERAL, d);
      rd_chk(PCP_OFS_GENERAL, d);
      `CHK("general copy", d, gen)
    end
    done("newer layout");
    wr(PCP_OFS_IDENT, {4'h0, PCP_REV_OLD});
    for (int i = 0; i < 24; i++) begin
      d = rnd();
      if (i < 8) d = {d[7:6], i[1:0], d[3:0]};
      @(posedge sys_clk_in);
      inserted <= (i < 8) ? i[2] : d[6];
      level <= d[2];
      repeat (2) @(posedge sys_clk_in);
      wr(PCP_OFS_POWER, d);
      rd_chk(PCP_OFS_POWER, d & PCP_OLD_WRITE_MASK);
      out_chk(d, 1'b1);
      s = exp_sup(d, 1'b1);
      rd_chk(PCP_OFS_STATUS, {1'b0, s != PCP_SUPPLY_0V, 2'b00, {2{inserted}}, 2'b00});
    end
    done("older layout");
    for (int w = 1; w >= 0; w--) begin
      wr(PCP_OFS_POWER, 8'hFF);
      wr(PCP_OFS_GENERAL, 8'hFF);
      @(posedge sys_clk_in);
      wake <= w[0];
      bus_reset_n <= 1'b0;
      @(posedge sys_clk_in);
      bus_reset_n <= 1'b1;
      rd_chk(PCP_OFS_POWER, w ? PCP_OLD_KEEP_MASK : 8'h00);
      rd_chk(PCP_OFS_GENERAL, w ? PCP_GENERAL_KEEP_MASK : 8'h00);
    end
    rd_chk(PCP_OFS_IDENT, {4'h0, PCP_REV_OLD});
    wr(PCP_OFS_POWER, 8'h90);
    @(posedge sys_clk_in);
    wake <= 1'b1;
    global_reset_n <= 1'b0;
    @(posedge sys_clk_in);
    global_reset_n <= 1'b1;
    rd_chk(PCP_OFS_IDENT, {4'h0, PCP_REV_RESET});
    rd_chk(PCP_OFS_POWER, PCP_POWER_RESET);
    `CHK("output enable after reset", 1'b0, oe)
    wr(PCP_OFS_POWER, 8'hFF);
    @(posedge sys_clk_in);
    bus_reset_n <= 1'b0;
    @(posedge sys_clk_in);
    bus_reset_n <= 1'b1;
    rd_chk(PCP_OFS_POWER, PCP_NEW_KEEP_MASK);
    `CHK("output enable kept", 1'b1, oe)
    done("resets");
    summarize();
  end
endmodule
